// [src/serial_port_buffer_flags.sv]
// Buffering, flags and register access of the serial port.
//
// Contract
// - Buffer-empty flag is high exactly while the transmit buffer is empty.
// - Buffer-empty request stays up while enabled, flag set, global enable.
// - Writing the data location clears the buffer-empty flag.
// - Transmit-complete sets when the frame is out and buffer is empty.
// - Transmit-complete clears on service or on a written one.
// - Transmit-complete request follows the flag when enabled, with global enable.
// - With parity enabled a parity bit precedes the first stop bit.
// - Transmitter disable waits for empty shifter and buffer, frees pin.
// - Receiver enable claims the serial input pin.
// - Synchronous mode receives on the external clock pin.
// - Receiver shifts bits up to the first stop bit, ignores second.
// - A complete frame moves to the receive buffer at the stop bit.
// - Unused high data bits read as zero for short characters.
// - Ninth bit and error flags travel with each frame; read advances.
// - Receive-complete flag is high exactly while unread data is held.
// - Receiver disable flushes the buffer and drops receive-complete.
// - Receive-complete request stays up while flag, enable, global.
// - Buffered character loads when shifter idle or frame finished.
// - Parity is the data exclusive-or, inverted for odd parity.
// - Two-frame buffer; overrun when full, one waiting, new start.
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module serial_port_buffer_flags (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [serial_port_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bit_tick_tx,
  input wire logic bit_tick_rx,
  input wire logic global_irq_enable,
  input wire logic tx_complete_irq_ack,
  input wire logic serial_in_pin,
  input wire logic sync_clock_pin,
  output logic serial_out_pin_o,
  output logic serial_out_pin_oe,
  output logic serial_in_claimed,
  output logic irq_tx_empty,
  output logic irq_tx_complete,
  output logic irq_rx_complete
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef logic [serial_port_pkg::ENT_W-1:0] entry_t;

  typedef struct packed {
    logic [1:0] rxd_sync;
    logic [2:0] xck_sync;
    logic [7:0] csb;
    logic [7:0] csc;
    logic [8:0] tx_buf;
    logic tx_full;
    logic tx_active;
    logic tx_done;
    entry_t [serial_port_pkg::RX_DEPTH-1:0] fifo;
    logic rd_ptr;
    logic [1:0] count;
    entry_t pend;
    logic pend_v;
    logic ovr;
    logic [31:0] rdata;
  } state_s;

  localparam state_s STATE_RESET = '{
    rxd_sync: 2'h3,
    csb: serial_port_pkg::CSB_RESET,
    csc: serial_port_pkg::CSC_RESET,
    default: '0
  };

  state_s s_q;
  state_s s_d;
  logic setup_rd;
  logic acc_wr;
  logic acc_rd;
  logic mapped;
  logic pop;
  logic room;
  logic push_v;
  logic sync_mode;
  logic tx_tick;
  logic rx_tick;
  logic tx_busy;
  logic tx_done_p;
  logic tx_line;
  logic tx_load;
  logic rx_on;
  logic rx_start;
  logic rx_valid;
  logic rx_ferr;
  logic rx_perr;
  logic rx_has;
  logic [8:0] rx_data;
  logic [3:0] nbits;
  logic [1:0] cnt;
  logic ptr;
  entry_t head;
  entry_t rx_ent;
  entry_t push_e;
  logic [7:0] csa_val;
  logic [7:0] csb_val;

  // ----------------------------------------------------------------
  // Decoding and pin control
  // ----------------------------------------------------------------
  assign nbits = serial_port_pkg::data_bits({
    s_q.csb[serial_port_pkg::CSB_CSZ2],
    s_q.csc[serial_port_pkg::CSC_CSZ_HI:serial_port_pkg::CSC_CSZ_LO]});
  assign sync_mode = s_q.csc[serial_port_pkg::CSC_SYNC];
  assign tx_tick = sync_mode ? (!s_q.xck_sync[1] && s_q.xck_sync[2])
                             : bit_tick_tx;
  assign rx_tick = sync_mode ? (s_q.xck_sync[1] && !s_q.xck_sync[2])
                             : bit_tick_rx;
  assign rx_on = s_q.csb[serial_port_pkg::CSB_RXON];
  assign serial_in_claimed = rx_on;
  assign serial_out_pin_oe = s_q.tx_active;
  assign serial_out_pin_o = tx_line;
  assign tx_load = s_q.tx_full && s_q.tx_active && !tx_busy;
  assign rx_has = s_q.count != 2'h0;
  assign head = s_q.fifo[s_q.rd_ptr];
  assign rx_ent = {s_q.ovr, rx_perr, rx_ferr, rx_data};

  assign setup_rd = psel && !penable && !pwrite;
  assign acc_wr = psel && penable && pwrite;
  assign acc_rd = psel && penable && !pwrite;
  assign mapped = paddr == serial_port_pkg::OFS_DATA
               || paddr == serial_port_pkg::OFS_CSA
               || paddr == serial_port_pkg::OFS_CSB
               || paddr == serial_port_pkg::OFS_CSC;
  assign pready = 1'h1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = s_q.rdata;
  assign pop = acc_rd && paddr == serial_port_pkg::OFS_DATA && rx_has;

  assign csa_val = {rx_has, s_q.tx_done, !s_q.tx_full,
                    head[serial_port_pkg::ENT_FERR] && rx_has,
                    head[serial_port_pkg::ENT_OVR] && rx_has,
                    head[serial_port_pkg::ENT_PERR] && rx_has,
                    2'h0};
  assign csb_val = {s_q.csb[7:2], head[8] && rx_has,
                    s_q.csb[serial_port_pkg::CSB_TX9]};

  assign irq_tx_empty = global_irq_enable && !s_q.tx_full
    && s_q.csb[serial_port_pkg::CSB_TXEIE];
  assign irq_tx_complete = global_irq_enable && s_q.tx_done
    && s_q.csb[serial_port_pkg::CSB_TXCIE];
  assign irq_rx_complete = global_irq_enable && rx_has
    && s_q.csb[serial_port_pkg::CSB_RXIE];

  // ----------------------------------------------------------------
  // Shift registers
  // ----------------------------------------------------------------
  serial_tx_shifter u_tx (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .tick(tx_tick),
    .load(tx_load),
    .data(s_q.tx_buf),
    .nbits(nbits),
    .par_en(s_q.csc[serial_port_pkg::CSC_PEN]),
    .par_odd(s_q.csc[serial_port_pkg::CSC_PODD]),
    .two_stop(s_q.csc[serial_port_pkg::CSC_STOP2]),
    .busy(tx_busy),
    .done(tx_done_p),
    .line(tx_line)
  );

  serial_rx_shifter u_rx (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .enable(rx_on),
    .tick(rx_tick),
    .line(s_q.rxd_sync[1]),
    .nbits(nbits),
    .par_en(s_q.csc[serial_port_pkg::CSC_PEN]),
    .par_odd(s_q.csc[serial_port_pkg::CSC_PODD]),
    .start_seen(rx_start),
    .valid(rx_valid),
    .data(rx_data),
    .ferr(rx_ferr),
    .perr(rx_perr)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.rxd_sync = {s_q.rxd_sync[0], serial_in_pin};
    s_d.xck_sync = {s_q.xck_sync[1:0], sync_clock_pin};
    cnt = s_q.count;
    ptr = s_q.rd_ptr;
    push_v = 1'h0;
    push_e = rx_ent;
    if (setup_rd) begin
      case (paddr)
        serial_port_pkg::OFS_DATA: s_d.rdata = {24'h000000, head[7:0]};
        serial_port_pkg::OFS_CSA: s_d.rdata = {24'h000000, csa_val};
        serial_port_pkg::OFS_CSB: s_d.rdata = {24'h000000, csb_val};
        serial_port_pkg::OFS_CSC: s_d.rdata = {24'h000000, s_q.csc};
        default: s_d.rdata = 32'h00000000;
      endcase
    end
    if (acc_wr && paddr == serial_port_pkg::OFS_CSB) begin
      s_d.csb = pwdata[7:0] & serial_port_pkg::CSB_WMASK;
    end
    if (acc_wr && paddr == serial_port_pkg::OFS_CSC) begin
      s_d.csc = pwdata[7:0] & serial_port_pkg::CSC_WMASK;
    end
    // Transmit side.
    if (tx_load) begin
      s_d.tx_full = 1'h0;
    end
    if (acc_wr && paddr == serial_port_pkg::OFS_DATA) begin
      s_d.tx_buf = {s_q.csb[serial_port_pkg::CSB_TX9], pwdata[7:0]};
      s_d.tx_full = 1'h1;
    end
    s_d.tx_active = s_q.csb[serial_port_pkg::CSB_TXON]
      || (s_q.tx_active && (tx_busy || s_q.tx_full));
    if (tx_complete_irq_ack || (acc_wr && paddr == serial_port_pkg::OFS_CSA
        && pwdata[serial_port_pkg::CSA_TXDONE])) begin
      s_d.tx_done = 1'h0;
    end
    if (tx_done_p && !s_q.tx_full) begin
      s_d.tx_done = 1'h1;
    end
    // Receive side.
    if (pop) begin
      ptr = !s_q.rd_ptr;
      cnt = s_q.count - 2'h1;
    end
    room = cnt < 2'(serial_port_pkg::RX_DEPTH);
    if (s_q.pend_v && room) begin
      push_v = 1'h1;
      push_e = s_q.pend;
      s_d.pend_v = rx_valid;
      s_d.pend = rx_ent;
    end else if (rx_valid && room) begin
      push_v = 1'h1;
    end else if (rx_valid) begin
      s_d.pend_v = 1'h1;
      s_d.pend = rx_ent;
    end
    if (rx_valid) begin
      s_d.ovr = 1'h0;
    end
    if (rx_start && s_q.pend_v && !room) begin
      s_d.pend_v = 1'h0;
      s_d.ovr = 1'h1;
    end
    if (push_v) begin
      s_d.fifo[1'(ptr + cnt)] = push_e;
      cnt = cnt + 2'h1;
    end
    s_d.count = cnt;
    s_d.rd_ptr = ptr;
    if (!rx_on) begin
      s_d.count = 2'h0;
      s_d.pend_v = 1'h0;
      s_d.ovr = 1'h0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= STATE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_data_write_empty: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    acc_wr && paddr == serial_port_pkg::OFS_DATA
    |=> !csa_val[serial_port_pkg::CSA_TXEMPTY] && !irq_tx_empty)
    else $error("Data write did not clear buffer empty.");

  chk_empty_irq_level: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    global_irq_enable && !s_q.tx_full
    && s_q.csb[serial_port_pkg::CSB_TXEIE] |-> irq_tx_empty)
    else $error("Buffer empty request missing.");

  chk_tx_done_set: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    tx_done_p && !s_q.tx_full |=> s_q.tx_done)
    else $error("Transmit complete not set.");

  chk_tx_done_ack: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    tx_complete_irq_ack && !tx_done_p |=> !s_q.tx_done)
    else $error("Transmit complete not cleared on service.");

  chk_tx_done_irq: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(s_q.tx_done) && global_irq_enable
    && s_q.csb[serial_port_pkg::CSB_TXCIE] |-> irq_tx_complete)
    else $error("Transmit complete request missing.");

  chk_tx_release: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !s_q.csb[serial_port_pkg::CSB_TXON] && !tx_busy && !s_q.tx_full
    |=> !serial_out_pin_oe)
    else $error("Output pin not released.");

  chk_tx_hold_pin: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    s_q.tx_active && tx_busy |=> serial_out_pin_oe)
    else $error("Output pin released mid frame.");

  chk_rx_flush: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !rx_on |=> s_q.count == 2'h0 && !irq_rx_complete)
    else $error("Receive buffer not flushed.");

  chk_rx_arrival: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    rx_on && rx_valid && s_q.count == 2'h0 && !s_q.pend_v
    |=> s_q.count == 2'h1 ##0 csa_val[serial_port_pkg::CSA_RXDONE])
    else $error("Received frame not buffered.");

  chk_rx_irq: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    irq_rx_complete |-> s_q.count != 2'h0 && global_irq_enable)
    else $error("Receive request without data.");

  chk_overrun_mark: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    rx_on && rx_start && s_q.pend_v && s_q.count == 2'h2 && !pop
    |=> s_q.ovr && !s_q.pend_v)
    else $error("Overrun not flagged.");

endmodule

// [src/serial_port_pkg.sv]
// Constants shared by the serial port buffer and flag logic.
package serial_port_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFS_DATA = 4'h0;
  localparam logic [3:0] OFS_CSA = 4'h4;
  localparam logic [3:0] OFS_CSB = 4'h8;
  localparam logic [3:0] OFS_CSC = 4'hC;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CSA_RXDONE = 7;
  localparam int CSA_TXDONE = 6;
  localparam int CSA_TXEMPTY = 5;
  localparam int CSA_FERR = 4;
  localparam int CSA_OVR = 3;
  localparam int CSA_PERR = 2;
  localparam int CSB_RXIE = 7;
  localparam int CSB_TXCIE = 6;
  localparam int CSB_TXEIE = 5;
  localparam int CSB_RXON = 4;
  localparam int CSB_TXON = 3;
  localparam int CSB_CSZ2 = 2;
  localparam int CSB_RX9 = 1;
  localparam int CSB_TX9 = 0;
  localparam int CSC_SYNC = 6;
  localparam int CSC_PEN = 5;
  localparam int CSC_PODD = 4;
  localparam int CSC_STOP2 = 3;
  localparam int CSC_CSZ_HI = 2;
  localparam int CSC_CSZ_LO = 1;
  localparam logic [7:0] CSB_WMASK = 8'hFD;
  localparam logic [7:0] CSC_WMASK = 8'h7E;

  // ----------------------------------------------------------------
  // Reset values and sizes
  // ----------------------------------------------------------------
  localparam logic [7:0] CSB_RESET = 8'h00;
  localparam logic [7:0] CSC_RESET = 8'h06;
  localparam int RX_DEPTH = 2;
  localparam int ENT_W = 12;
  localparam int ENT_OVR = 11;
  localparam int ENT_PERR = 10;
  localparam int ENT_FERR = 9;
  localparam int FRAME_W = 13;

  function automatic logic [3:0] data_bits(input logic [2:0] cs);
    case (cs)
      3'h0: data_bits = 4'h5;
      3'h1: data_bits = 4'h6;
      3'h2: data_bits = 4'h7;
      3'h7: data_bits = 4'h9;
      default: data_bits = 4'h8;
    endcase
  endfunction

endpackage

// [src/serial_rx_shifter.sv]
// Receive shift register that gathers one frame and checks it.
`timescale 1ns/1ps
module serial_rx_shifter (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic tick,
  input wire logic line,
  input wire logic [3:0] nbits,
  input wire logic par_en,
  input wire logic par_odd,
  output logic start_seen,
  output logic valid,
  output logic [8:0] data,
  output logic ferr,
  output logic perr
);

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_DATA = 2'b01,
    RX_PAR = 2'b10,
    RX_STOP = 2'b11
  } rx_state_e;

  typedef struct packed {
    rx_state_e st;
    logic [3:0] idx;
    logic [8:0] data;
    logic par;
    logic valid;
    logic ferr;
    logic perr;
  } state_s;

  state_s s_q;
  state_s s_d;

  assign valid = s_q.valid;
  assign data = s_q.data;
  assign ferr = s_q.ferr;
  assign perr = s_q.perr;

  always_comb begin
    s_d = s_q;
    s_d.valid = 1'h0;
    start_seen = 1'h0;
    if (!enable) begin
      s_d.st = RX_IDLE;
    end else if (tick) begin
      case (s_q.st)
        RX_IDLE: begin
          if (!line) begin
            s_d.st = RX_DATA;
            s_d.idx = 4'h0;
            s_d.data = 9'h000;
            start_seen = 1'h1;
          end
        end
        RX_DATA: begin
          s_d.data[s_q.idx] = line;
          s_d.idx = s_q.idx + 4'h1;
          if (s_q.idx + 4'h1 == nbits) begin
            s_d.st = par_en ? RX_PAR : RX_STOP;
          end
        end
        RX_PAR: begin
          s_d.par = line;
          s_d.st = RX_STOP;
        end
        RX_STOP: begin
          s_d.ferr = !line;
          s_d.perr = par_en && (s_q.par != (par_odd ^ (^s_q.data)));
          s_d.valid = 1'h1;
          s_d.st = RX_IDLE;
        end
        default: s_d.st = RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// [src/serial_tx_shifter.sv]
// Transmit shift register that frames and sends one character.
`timescale 1ns/1ps
module serial_tx_shifter #(
  parameter int FRAME_W = serial_port_pkg::FRAME_W
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic load,
  input wire logic [8:0] data,
  input wire logic [3:0] nbits,
  input wire logic par_en,
  input wire logic par_odd,
  input wire logic two_stop,
  output logic busy,
  output logic done,
  output logic line
);

  if (FRAME_W < 13) begin : g_chk
    $error("Frame register too narrow.");
  end

  typedef struct packed {
    logic [FRAME_W-1:0] sh;
    logic [3:0] cnt;
    logic line;
  } state_s;

  state_s s_q;
  state_s s_d;
  logic [FRAME_W-1:0] frame;
  logic par;

  assign busy = s_q.cnt != 4'h0;
  assign done = tick && s_q.cnt == 4'h1;
  assign line = s_q.line;

  always_comb begin
    s_d = s_q;
    frame = '1;
    frame[0] = 1'h0;
    par = par_odd;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < nbits) begin
        frame[i + 1] = data[i];
        par = par ^ data[i];
      end
    end
    if (par_en) begin
      frame[nbits + 4'h1] = par;
    end
    if (load) begin
      s_d.sh = frame >> 1;
      s_d.line = 1'h0;
      s_d.cnt = nbits + 4'h2 + {3'h0, par_en} + {3'h0, two_stop};
    end else if (tick && busy) begin
      s_d.cnt = s_q.cnt - 4'h1;
      s_d.line = (s_q.cnt == 4'h1) ? 1'h1 : s_q.sh[0];
      s_d.sh = {1'h1, s_q.sh[FRAME_W-1:1]};
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{sh: '1, cnt: 4'h0, line: 1'h1};
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// [testbench/peer.sv]
// Remote serial node that drives the receive line and captures sent frames.
`timescale 1ns/1ps
module peer (
  input wire logic clk_sys,
  input wire logic tick_tx,
  input wire logic tick_rx,
  input wire logic line_o,
  input wire logic line_oe,
  output logic line_i,
  output logic got,
  output logic got_bad,
  output logic [8:0] got_data
);
  int nbits = 8;
  int cnt = -1;
  logic pen = 1'b0;
  logic podd = 1'b0;
  logic [8:0] sh;
  logic [8:0] msk;
  logic lvl;
  logic par;
  initial line_i = 1'b1;
  initial got = 1'b0;
  // The line idles high whenever the port does not drive it.
  assign lvl = line_oe ? line_o : 1'b1;
  assign msk = 9'((32'h1 << nbits) - 32'h1);

  // Sends one frame; the two flags corrupt the parity or the stop bit.
  task automatic send(input logic [8:0] d, input logic bp, input logic bs);
    logic p;
    p = ^(d & msk) ^ podd ^ bp;
    @(posedge clk_sys iff tick_rx);
    line_i <= 1'b0;
    for (int i = 0; i < nbits; i++) begin
      @(posedge clk_sys iff tick_rx);
      line_i <= d[i];
    end
    if (pen) begin
      @(posedge clk_sys iff tick_rx);
      line_i <= p;
    end
    @(posedge clk_sys iff tick_rx);
    line_i <= ~bs;
    @(posedge clk_sys iff tick_rx);
    line_i <= 1'b1;
  endtask

  // Samples the line at each transmit tick, before that tick moves it.
  always @(posedge clk_sys) begin
    got <= 1'b0;
    if (tick_tx) begin
      if (cnt < 0) begin
        sh = 9'h000;
        if (!lvl) cnt = 0;
      end else if (cnt < nbits) begin
        sh[cnt] = lvl;
        cnt++;
      end else if (pen && cnt == nbits) begin
        par = lvl;
        cnt++;
      end else begin
        got <= 1'b1;
        got_data <= sh;
        got_bad <= !lvl || (pen && (par !== (^sh ^ podd)));
        cnt = -1;
      end
    end
  end
endmodule

// [testbench/serial_port_buffer_flags_tb.sv]
// Self-checking bench for the serial port buffer and flag logic.
`timescale 1ns/1ps
module serial_port_buffer_flags_tb;
  localparam logic [3:0] A_D = serial_port_pkg::OFS_DATA;
  localparam logic [3:0] A_A = serial_port_pkg::OFS_CSA;
  localparam logic [3:0] A_B = serial_port_pkg::OFS_CSB;
  localparam logic [3:0] A_C = serial_port_pkg::OFS_CSC;
  localparam logic [32:0] ALL = 33'h1FFFFFFFF;
  logic clk_sys = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, gie = 1'b0, ack = 1'b0, tk_tx = 1'b0, tk_rx = 1'b0;
  logic xck = 1'b0;
  logic [3:0] paddr = 4'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, sin, sout, soe, claimed, irq_te, irq_tc, irq_rc;
  logic got, got_bad;
  logic [8:0] got_data, v;
  logic [8:0] fr[4];
  logic [32:0] e, m;
  logic [32:0] eq[$], mq[$];
  logic [9:0] txq[$];
  int bad_count = 0;
  int cmp_count = 0;
  int seed = 52912;
  int tcnt = 0;

  serial_port_buffer_flags serial_port_buffer_flags_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bit_tick_tx(tk_tx),
    .bit_tick_rx(tk_rx), .global_irq_enable(gie),
    .tx_complete_irq_ack(ack), .serial_in_pin(sin), .sync_clock_pin(xck),
    .serial_out_pin_o(sout), .serial_out_pin_oe(soe),
    .serial_in_claimed(claimed), .irq_tx_empty(irq_te),
    .irq_tx_complete(irq_tc), .irq_rx_complete(irq_rc));
  peer peer_i (
    .clk_sys(clk_sys), .tick_tx(tk_tx), .tick_rx(tk_rx), .line_o(sout),
    .line_oe(soe), .line_i(sin), .got(got), .got_bad(got_bad),
    .got_data(got_data));

  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    tcnt <= tcnt + 1;
    tk_tx <= (tcnt % 4 == 0);
    tk_rx <= (tcnt % 5 == 0);
    xck <= (tcnt % 5 < 2);
  end

  function automatic logic [8:0] rnd();
    rnd = {1'b0, 8'($random(seed))};
  endfunction
  task automatic check(input string s, input logic [32:0] x,
                       input logic [32:0] y);
    cmp_count++;
    if (y !== x) begin
      bad_count++;
      $display("Error %s expected %h seen %h", s, x, y);
    end
  endtask
  task automatic apb(input logic w, input logic [3:0] a,
                     input logic [7:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, wd};
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [3:0] a, input logic [32:0] x,
                    input logic [32:0] mk);
    eq.push_back(x);
    mq.push_back(mk);
    apb(1'b0, a, 8'h00);
  endtask
  task automatic wt(input logic rx);
    while ((rx ? irq_rc : irq_tc) !== 1'b1) @(posedge clk_sys);
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic finish_test;
    $display("Checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Compares each read and each captured frame with the oldest note.
  always @(posedge clk_sys) begin
    if (psel && penable && !pwrite && pready) begin
      e = eq.pop_front();
      m = mq.pop_front();
      check("read", e & m, {pslverr, prdata} & m);
    end
    if (got) begin
      check("frame", 33'(txq.pop_front()), 33'({got_bad, got_data}));
    end
  end

  initial begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd(A_A, 33'h20, 33'h1FFFFFFFC);
    rd(A_B, 33'h00, ALL);
    rd(A_C, 33'h06, ALL);
    rd(4'h2, 33'h100000000, ALL);
    apb(1'b1, A_B, 8'hFA);
    rd(A_B, 33'hF8, ALL);
    gie <= 1'b1;
    @(posedge clk_sys);
    check("irq empty", 33'h1, 33'(irq_te));
    check("claimed", 33'h1, 33'(claimed));
    for (int k = 0; k < 4; k++) begin
      peer_i.pen = k[1];
      peer_i.podd = k[0];
      apb(1'b1, A_C, 8'(8'h06 | (k << 4)));
      for (int j = 0; j < 2; j++) begin
        v = rnd();
        txq.push_back({1'b0, v});
        apb(1'b1, A_D, v[7:0]);
      end
      check("irq empty", 33'h0, 33'(irq_te));
      while (irq_te !== 1'b1) @(posedge clk_sys);
      wt(1'b0);
      check("tx left", 33'h0, 33'(txq.size()));
      if (k[0]) begin
        ack <= 1'b1;
        @(posedge clk_sys);
        ack <= 1'b0;
        @(posedge clk_sys);
      end else begin
        apb(1'b1, A_A, 8'h40);
      end
      check("irq done", 33'h0, 33'(irq_tc));
    end
    apb(1'b1, A_C, 8'h06);
    apb(1'b1, A_B, 8'hFD);
    peer_i.pen = 1'b0;
    peer_i.nbits = 9;
    txq.push_back(10'h1A5);
    apb(1'b1, A_D, 8'hA5);
    wt(1'b0);
    apb(1'b1, A_A, 8'h40);
    peer_i.send(9'h15A, 1'b0, 1'b0);
    wt(1'b1);
    rd(A_B, 33'h02, 33'h02);
    rd(A_D, 33'h5A, ALL);
    apb(1'b1, A_B, 8'hF8);
    peer_i.nbits = 8;
    for (int k = 0; k < 4; k++) begin
      fr[k] = rnd();
      peer_i.send(fr[k], 1'b0, 1'b0);
    end
    wt(1'b1);
    check("irq rx", 33'h1, 33'(irq_rc));
    rd(A_A, 33'h80, 33'h88);
    rd(A_D, 33'(fr[0]), ALL);
    rd(A_D, 33'(fr[1]), ALL);
    rd(A_A, 33'h88, 33'h88);
    rd(A_D, 33'(fr[3]), ALL);
    rd(A_A, 33'h00, 33'h80);
    apb(1'b1, A_C, 8'h26);
    peer_i.pen = 1'b1;
    peer_i.podd = 1'b0;
    v = rnd();
    peer_i.send(v, 1'b1, 1'b0);
    fr[0] = rnd();
    peer_i.send(fr[0], 1'b0, 1'b1);
    rd(A_A, 33'h84, 33'h9C);
    rd(A_D, 33'(v), ALL);
    rd(A_A, 33'h90, 33'h9C);
    rd(A_D, 33'(fr[0]), ALL);
    apb(1'b1, A_C, 8'h00);
    peer_i.pen = 1'b0;
    peer_i.nbits = 5;
    v = rnd();
    peer_i.send(v, 1'b0, 1'b0);
    wt(1'b1);
    rd(A_D, 33'(v & 9'h01F), ALL);
    apb(1'b1, A_C, 8'h46);
    peer_i.nbits = 8;
    peer_i.send(v, 1'b0, 1'b0);
    wt(1'b1);
    rd(A_D, 33'(v), ALL);
    peer_i.send(v, 1'b0, 1'b0);
    wt(1'b1);
    apb(1'b1, A_B, 8'hE8);
    @(posedge clk_sys);
    check("claimed", 33'h0, 33'(claimed));
    check("irq rx", 33'h0, 33'(irq_rc));
    apb(1'b1, A_B, 8'hF8);
    rd(A_A, 33'h00, 33'h80);
    apb(1'b1, A_C, 8'h0E);
    gie <= 1'b0;
    @(posedge clk_sys);
    check("irq gated", 33'h0, 33'(irq_te));
    gie <= 1'b1;
    v = rnd();
    txq.push_back({1'b0, v});
    apb(1'b1, A_D, v[7:0]);
    apb(1'b1, A_B, 8'hF0);
    check("pin owned", 33'h1, 33'(soe));
    wt(1'b0);
    check("pin freed", 33'h0, 33'(soe));
    check("left", 33'h0, 33'(eq.size() + txq.size()));
    finish_test();
  end

  initial begin
    repeat (40000) @(posedge clk_sys);
    bad_count++;
    finish_test();
  end
endmodule
